// ---- common/pph_pkg.sv ----
// Constants for the parameter page header generator
package pph_pkg;
    localparam int          PAGE_BYTES     = 256;
    localparam int          PAGE_COPIES    = 3;
    localparam int          HDR_BYTES      = 32;
    localparam logic [7:0]  SIG_B0         = 8'h4f;
    localparam logic [7:0]  SIG_B1         = 8'h4e;
    localparam logic [7:0]  SIG_B2         = 8'h46;
    localparam logic [7:0]  SIG_B3         = 8'h49;
    localparam logic [15:0] REV_MAP        = 16'h003e;
    localparam logic [15:0] FEAT_BASE      = 16'h01d8;
    localparam int          FEAT_SYNC_BIT  = 5;
    localparam int          FEAT_MLUN_BIT  = 1;
    localparam logic [15:0] OPT_CMD_MAP    = 16'h03ff;
    localparam logic [15:0] EXT_PAGE_LEN   = 16'h0003;
    localparam logic [7:0]  NUM_PAGES      = 8'h1d;
    localparam logic [7:0]  CMD_READ_PARAM = 8'hec;
    localparam logic [7:0]  ADDR_ONFI      = 8'h00;
    localparam logic [7:0]  ADDR_JEDEC     = 8'h40;
    localparam int          FIFO_DEPTH     = 4;
    typedef enum logic [1:0] {PPH_IDLE, PPH_RUN, PPH_DONE} pph_state_t;
endpackage

// ---- design/pph_fifo.sv ----
// Small valid/ready FIFO with registered read data
`timescale 1ns/100ps
module pph_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // Refused at elaboration: pointers wrap by plain overflow
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
    begin
        $error("pph_fifo: DEPTH must be a power of two, at least 2");
    end

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0]    wr_ptr_ff;
    logic [AW-1:0]    rd_ptr_ff;
    logic [AW:0]      count_ff;
    logic             out_valid_ff;

    // Registered output stage counts as one extra slot
    wire  push      = in_valid && in_ready;
    wire  pop_out   = out_valid_ff && out_ready;
    wire  mem_empty = (count_ff == '0);
    wire  load_out  = !mem_empty && (!out_valid_ff || out_ready);
    wire  [AW:0] nxt_count = count_ff + (AW+1)'(push) - (AW+1)'(load_out);

    assign in_ready  = (count_ff != (AW+1)'(DEPTH));
    assign out_valid = out_valid_ff;

    always_ff @(posedge clk)
    begin
        if (push)
            mem_ff[wr_ptr_ff] <= in_data;
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            wr_ptr_ff    <= '0;
            rd_ptr_ff    <= '0;
            count_ff     <= '0;
            out_valid_ff <= 1'b0;
            out_data     <= '0;
        end
        else
        begin
            count_ff <= nxt_count;
            if (push)
                wr_ptr_ff <= wr_ptr_ff + AW'(1);
            if (load_out)
            begin
                out_data     <= mem_ff[rd_ptr_ff];
                rd_ptr_ff    <= rd_ptr_ff + AW'(1);
                out_valid_ff <= 1'b1;
            end
            else if (pop_out)
                out_valid_ff <= 1'b0;
        end
    end

    chk_fifo_no_overflow: assert property (@(posedge clk) disable iff (reset)
        count_ff <= (AW+1)'(DEPTH))
        else $error("FIFO count above depth");
    chk_fifo_out_hold: assert property (@(posedge clk) disable iff (reset)
        out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("FIFO output changed while stalled");
endmodule

// ---- design/pph_rom.sv ----
// Parameter page header generator: streams copies of the page to the host side
//
// Operation
// - Bytes 0-3 carry the ASCII signature
// - Bytes 4-5 carry revision bitmap 3Eh 00h
// - Feature bits 8,7,6,4,3 set, 15:9 clear
// - Sync and multi-LUN feature bits follow variant
// - Bytes 8-9 optional commands FFh 03h
// - Bytes 12-13 extended page length 03h 00h
// - Byte 14 is 1Dh, other bytes zero
// - 256-byte copies, at least three, back to back
// - Command ECh with address 00h selects page
// - One byte per read strobe edge, rising or falling
`timescale 1ns/100ps
module pph_rom
    import pph_pkg::*;
#(
    parameter int COPIES = pph_pkg::PAGE_COPIES,
    parameter int DEPTH  = pph_pkg::FIFO_DEPTH
) (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       var_sync,
    input  wire logic       var_multi_lun,
    input  wire logic       cmd_valid,
    input  wire logic [7:0] cmd_code,
    input  wire logic [7:0] cmd_addr,
    input  wire logic       byte_strobe,
    output logic [7:0]      data_out,
    output logic            data_valid,
    output logic            busy,
    output logic            cmd_error
);
    import pph_pkg::*;

    if (COPIES < 3 || COPIES > 255)
    begin
        $error("pph_rom: COPIES must be 3..255");
    end

    localparam int CW = (COPIES > 1) ? $clog2(COPIES + 1) : 1;

    // Header byte lookup; offsets beyond the header read zero
    function automatic logic [7:0] hdr_byte(input logic [7:0] off,
                                            input logic [15:0] feat);
        case (off)
            8'h00:   hdr_byte = SIG_B0;
            8'h01:   hdr_byte = SIG_B1;
            8'h02:   hdr_byte = SIG_B2;
            8'h03:   hdr_byte = SIG_B3;
            8'h04:   hdr_byte = REV_MAP[7:0];
            8'h05:   hdr_byte = REV_MAP[15:8];
            8'h06:   hdr_byte = feat[7:0];
            8'h07:   hdr_byte = feat[15:8];
            8'h08:   hdr_byte = OPT_CMD_MAP[7:0];
            8'h09:   hdr_byte = OPT_CMD_MAP[15:8];
            8'h0c:   hdr_byte = EXT_PAGE_LEN[7:0];
            8'h0d:   hdr_byte = EXT_PAGE_LEN[15:8];
            8'h0e:   hdr_byte = NUM_PAGES;
            default: hdr_byte = 8'h00;
        endcase
    endfunction

    // Straps sampled as pins
    logic [1:0] sync_meta_ff;
    logic [1:0] mlun_meta_ff;
    logic [1:0] strb_meta_ff;
    logic       strb_prev_ff;

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            sync_meta_ff <= '0;
            mlun_meta_ff <= '0;
            strb_meta_ff <= '0;
            strb_prev_ff <= 1'b0;
        end
        else
        begin
            sync_meta_ff <= {sync_meta_ff[0], var_sync};
            mlun_meta_ff <= {mlun_meta_ff[0], var_multi_lun};
            strb_meta_ff <= {strb_meta_ff[0], byte_strobe};
            strb_prev_ff <= strb_meta_ff[1];
        end
    end

    wire [15:0] feat_map = FEAT_BASE
                         | (16'(sync_meta_ff[1]) << FEAT_SYNC_BIT)
                         | (16'(mlun_meta_ff[1]) << FEAT_MLUN_BIT);

    // Any edge of the read strobe takes one byte
    wire strobe_edge = strb_meta_ff[1] ^ strb_prev_ff;

    pph_state_t state_ff;
    pph_state_t nxt_state;
    logic [7:0]    offset_ff;
    logic [CW-1:0] copy_ff;
    logic          err_ff;

    wire cmd_ok  = cmd_valid && cmd_code == CMD_READ_PARAM
                   && cmd_addr == ADDR_ONFI;
    wire cmd_bad = cmd_valid && !cmd_ok;

    logic       gen_ready;
    wire        gen_valid = (state_ff == PPH_RUN);
    wire        gen_push  = gen_valid && gen_ready;
    wire [7:0]  gen_byte  = hdr_byte(offset_ff, feat_map);
    wire        last_byte = (offset_ff == 8'(PAGE_BYTES - 1));
    wire        last_copy = (copy_ff == CW'(COPIES - 1));

    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            PPH_IDLE: if (cmd_ok) nxt_state = PPH_RUN;
            PPH_RUN:  if (gen_push && last_byte && last_copy) nxt_state = PPH_DONE;
            PPH_DONE: if (cmd_ok) nxt_state = PPH_RUN;
            default:  nxt_state = PPH_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (reset)
        begin
            state_ff  <= PPH_IDLE;
            offset_ff <= '0;
            copy_ff   <= '0;
            err_ff    <= 1'b0;
        end
        else
        begin
            state_ff <= nxt_state;
            err_ff   <= cmd_bad;
            if (cmd_ok && state_ff != PPH_RUN)
            begin
                offset_ff <= '0;
                copy_ff   <= '0;
            end
            else if (gen_push)
            begin
                offset_ff <= offset_ff + 8'h01;
                if (last_byte)
                    copy_ff <= copy_ff + CW'(1);
            end
        end
    end

    logic fifo_valid;
    logic [7:0] fifo_data;

    pph_fifo #(
        .WIDTH (8),
        .DEPTH (DEPTH)
    ) u_fifo (
        .clk       (clk),
        .reset     (reset),
        .in_valid  (gen_valid),
        .in_ready  (gen_ready),
        .in_data   (gen_byte),
        .out_valid (fifo_valid),
        .out_ready (strobe_edge),
        .out_data  (fifo_data)
    );

    assign data_out   = fifo_data;
    assign data_valid = fifo_valid;
    assign busy       = (state_ff == PPH_RUN);
    assign cmd_error  = err_ff;

    sequence s_page_start;
        state_ff != PPH_RUN && cmd_ok;
    endsequence

    chk_start_run: assert property (@(posedge clk) disable iff (reset)
        s_page_start |=> busy && offset_ff == 8'h00 && copy_ff == '0)
        else $error("Page read did not start at offset zero");
    chk_sig_first: assert property (@(posedge clk) disable iff (reset)
        gen_push && offset_ff == 8'h00 |-> gen_byte == 8'h4f)
        else $error("Signature byte 0 wrong");
    chk_sig_last: assert property (@(posedge clk) disable iff (reset)
        gen_push && offset_ff == 8'h03 |-> gen_byte == 8'h49)
        else $error("Signature byte 3 wrong");
    chk_rev_low: assert property (@(posedge clk) disable iff (reset)
        gen_push && offset_ff == 8'h04 |-> gen_byte == 8'h3e)
        else $error("Revision low byte wrong");
    chk_feat_high: assert property (@(posedge clk) disable iff (reset)
        gen_push && offset_ff == 8'h07 |-> gen_byte == 8'h01)
        else $error("Feature high byte wrong");
    chk_feat_var: assert property (@(posedge clk) disable iff (reset)
        gen_push && offset_ff == 8'h06 |->
        gen_byte == {2'b11, sync_meta_ff[1], 2'b11, 1'b0, mlun_meta_ff[1], 1'b0})
        else $error("Feature low byte does not follow variant");
    chk_opt_cmd: assert property (@(posedge clk) disable iff (reset)
        gen_push && offset_ff == 8'h09 |-> gen_byte == 8'h03)
        else $error("Optional command high byte wrong");
    chk_ext_len: assert property (@(posedge clk) disable iff (reset)
        gen_push && offset_ff == 8'h0c |-> gen_byte == 8'h03)
        else $error("Extended page length wrong");
    chk_page_cnt: assert property (@(posedge clk) disable iff (reset)
        gen_push && offset_ff == 8'h0e |-> gen_byte == 8'h1d)
        else $error("Page count byte wrong");
    chk_zero_tail: assert property (@(posedge clk) disable iff (reset)
        gen_push && offset_ff >= 8'h0f |-> gen_byte == 8'h00)
        else $error("Reserved byte not zero");
    chk_copy_wrap: assert property (@(posedge clk) disable iff (reset)
        gen_push && last_byte && !last_copy |=> offset_ff == 8'h00 && busy)
        else $error("Copy did not wrap to offset zero");
    chk_one_byte: assert property (@(posedge clk) disable iff (reset)
        data_valid && !strobe_edge |=> data_valid && $stable(data_out))
        else $error("Byte changed without a strobe edge");
endmodule

// ---- bench/pph_host_model.sv ----
// Host-side reader model that pulls bytes from the parameter page stream
`timescale 1ns/100ps
module pph_host_model (
    input  wire logic       clk,
    input  wire logic [7:0] data_out,
    input  wire logic       data_valid,
    output logic            byte_strobe
);
    logic [7:0] got [0:767];
    initial byte_strobe = 1'b0;
    // Sample first, then toggle; both edges count, so each byte takes one toggle and parity need not be even
    task automatic read_bytes(input int n, input int gap);
        int i;
        int w;
        for (i = 0; i < n; i++)
        begin
            w = 0;
            while (data_valid !== 1'b1 && w < 200)
            begin
                @(posedge clk);
                #2;
                w++;
            end
            got[i] = (data_valid === 1'b1) ? data_out : 8'hxx;
            byte_strobe = ~byte_strobe;
            repeat (5 + gap) @(posedge clk);
            #2;
        end
    endtask
endmodule

// ---- bench/tb_top.sv ----
// Self-checking bench for the parameter page header generator
`timescale 1ns/100ps
module tb_top;
    import pph_pkg::*;
    logic       clk = 1'b0;
    logic       reset = 1'b1;
    logic       var_sync = 1'b0;
    logic       var_multi_lun = 1'b0;
    logic       cmd_valid = 1'b0;
    logic [7:0] cmd_code = 8'h00;
    logic [7:0] cmd_addr = 8'h00;
    logic       byte_strobe;
    logic [7:0] data_out;
    logic       data_valid;
    logic       busy;
    logic       cmd_error;
    int         mismatches = 0;
    int         total_checks = 0;
    logic [7:0] hdr [0:15] = '{8'h4f, 8'h4e, 8'h46, 8'h49, 8'h3e, 8'h00, 8'hd8, 8'h01,
                               8'hff, 8'h03, 8'h00, 8'h00, 8'h03, 8'h00, 8'h1d, 8'h00};
    always #12.5 clk = ~clk;
    pph_rom #(.COPIES(3), .DEPTH(4)) dut_u (
        .clk(clk), .reset(reset), .var_sync(var_sync), .var_multi_lun(var_multi_lun),
        .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_addr(cmd_addr),
        .byte_strobe(byte_strobe), .data_out(data_out), .data_valid(data_valid),
        .busy(busy), .cmd_error(cmd_error)
    );
    pph_host_model host_u (
        .clk(clk), .data_out(data_out), .data_valid(data_valid), .byte_strobe(byte_strobe)
    );
    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic got);
        total_checks++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected %s: expected %b, seen %b", what, exp, got);
        end
    endtask
    task automatic end_sim;
        if (mismatches == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Only byte 6 depends on the straps
    function automatic logic [7:0] exp_byte(input int off, input logic s, input logic m);
        logic [7:0] v;
        v = (off < 16) ? hdr[off] : 8'h00;
        if (off == 6)
            v = v | {2'b00, s, 3'b000, m, 1'b0};
        return v;
    endfunction
    // Straps change only under reset so the synchronizers settle first
    task automatic do_reset(input logic s, input logic m);
        var_sync = s;
        var_multi_lun = m;
        reset = 1'b1;
        repeat (6) @(posedge clk);
        #2;
        reset = 1'b0;
    endtask
    task automatic send_cmd(input logic [7:0] c, input logic [7:0] a);
        cmd_code = c;
        cmd_addr = a;
        cmd_valid = 1'b1;
        @(posedge clk);
        #2;
        cmd_valid = 1'b0;
    endtask
    task automatic t_refuse(input logic [7:0] c, input logic [7:0] a);
        send_cmd(c, a);
        chk_bit("cmd_error", 1'b1, cmd_error);
        chk_bit("busy on refused", 1'b0, busy);
        @(posedge clk);
        #2;
        chk_bit("cmd_error pulse", 1'b0, cmd_error);
        chk_bit("valid on refused", 1'b0, data_valid);
    endtask
    task automatic t_page(input logic s, input logic m, input int gap);
        int i;
        do_reset(s, m);
        send_cmd(8'hec, 8'h00);
        host_u.read_bytes(768, gap);
        for (i = 0; i < 768; i++)
            chk_byte("page byte", exp_byte(i % 256, s, m), host_u.got[i]);
        repeat (8) @(posedge clk);
        #2;
        chk_bit("busy after page", 1'b0, busy);
        chk_bit("valid after page", 1'b0, data_valid);
        // A new read after the last copy starts over at offset zero
        send_cmd(8'hec, 8'h00);
        host_u.read_bytes(16, 0);
        for (i = 0; i < 16; i++)
            chk_byte("byte after done", exp_byte(i, s, m), host_u.got[i]);
    endtask
    // A second start while busy must not rewind the offset
    task automatic t_restart;
        int i;
        do_reset(1'b0, 1'b1);
        send_cmd(8'hec, 8'h00);
        host_u.read_bytes(8, 0);
        for (i = 0; i < 8; i++)
            chk_byte("byte before restart", exp_byte(i, 1'b0, 1'b1), host_u.got[i]);
        send_cmd(8'hec, 8'h00);
        chk_bit("busy on restart", 1'b1, busy);
        chk_bit("cmd_error on restart", 1'b0, cmd_error);
        // Eight more bytes reach past what the FIFO already holds
        host_u.read_bytes(8, 1);
        for (i = 0; i < 8; i++)
            chk_byte("byte after restart", exp_byte(8 + i, 1'b0, 1'b1), host_u.got[i]);
    endtask
    initial
    begin
        int v;
        do_reset(1'b1, 1'b1);
        t_refuse(8'hec, 8'h40);
        t_refuse(8'h90, 8'h00);
        for (v = 0; v < 4; v++)
            t_page(v[1], v[0], (v == 3) ? 2 : 0);
        t_restart;
        end_sim;
    end
    // Four full pages at five to seven cycles a byte fit well inside this span
    initial
    begin
        repeat (40000) @(posedge clk);
        mismatches++;
        end_sim;
    end
endmodule
